/* File: include/tce_pkg.sv */
/*
 * Shared constants for the trainer CPU executor: machine-cycle phases, opcode groups, states and the
 * Wishbone register map. Assumes one 50 MHz clock and a byte-wide RAM outside the block.
 */
package tce_pkg;

	localparam int          DATA_W     = 8;
	localparam int          ADDR_W     = 16;
	localparam int          REG_COUNT  = 16;
	localparam int          REG_IDX_W  = 4;
	localparam int          MC_CLOCKS  = 8;
	localparam int          WB_ADR_W   = 8;

	// Phases inside one machine cycle of MC_CLOCKS clocks.
	localparam logic [2:0]  PH_LATCH   = 3'h1;
	localparam logic [2:0]  PH_MEMWR   = 3'h3;
	localparam logic [2:0]  PH_SAMPLE  = 3'h4;
	localparam logic [2:0]  PH_WRITE   = 3'h5;
	localparam logic [2:0]  PH_END     = 3'(MC_CLOCKS - 1);

	localparam logic [15:0] R0_CLEAR   = 16'h0000;
	localparam logic [15:0] PC_START   = 16'h0001;
	localparam logic [3:0]  INT_X_SEL  = 4'h2;
	localparam logic [3:0]  INT_P_SEL  = 4'h1;
	localparam logic [7:0]  OP_WAIT    = 8'h00;
	localparam logic [7:0]  OP_SAVE_T  = 8'h78;

	localparam logic [3:0]  OP_LOAD_VIA_N      = 4'h0;
	localparam logic [3:0]  OP_INCREMENT       = 4'h1;
	localparam logic [3:0]  OP_REG_DECREMENT   = 4'h2;
	localparam logic [3:0]  OP_SHORT_BRANCH    = 4'h3;
	localparam logic [3:0]  OP_LOAD_ADVANCE    = 4'h4;
	localparam logic [3:0]  OP_STORE_VIA_REG   = 4'h5;
	localparam logic [3:0]  OP_BYTE_IO         = 4'h6;
	localparam logic [3:0]  OP_CONTROL         = 4'h7;
	localparam logic [3:0]  OP_GET_LOW_BYTE    = 4'h8;
	localparam logic [3:0]  OP_GET_HIGH_BYTE   = 4'h9;
	localparam logic [3:0]  OP_PUT_LOW_BYTE    = 4'hA;
	localparam logic [3:0]  OP_PUT_HIGH_BYTE   = 4'hB;
	localparam logic [3:0]  OP_SET_PC_SELECTOR = 4'hD;
	localparam logic [3:0]  OP_SET_X_SELECTOR  = 4'hE;
	localparam logic [3:0]  OP_ALU             = 4'hF;

	localparam logic [2:0]  ALU_SHIFT_RIGHT    = 3'h6;

	typedef enum logic [2:0] {
		S_HALT    = 3'b000,
		S_FETCH   = 3'b001,
		S_EXEC    = 3'b010,
		S_DMA_IN  = 3'b011,
		S_DMA_OUT = 3'b100,
		S_INT     = 3'b101,
		S_WAIT    = 3'b110,
		S_START   = 3'b111
	} tce_state_t;

	localparam logic [WB_ADR_W-1:0] REG_CTRL    = 8'h00;
	localparam logic [WB_ADR_W-1:0] REG_STATUS  = 8'h04;
	localparam logic [WB_ADR_W-1:0] REG_INBYTE  = 8'h08;
	localparam logic [WB_ADR_W-1:0] REG_DISPLAY = 8'h0C;
	localparam int                  CTRL_SOFT_CLEAR = 0;
	localparam int                  CTRL_SW_INHIBIT = 1;
	localparam logic [7:0]          CTRL_RESET      = 8'h00;
	localparam logic [7:0]          INBYTE_RESET    = 8'h00;

endpackage

/* File: hw/tce_scratch_file.sv */
/*
 * Sixteen-entry scratch register file with one write port and a registered read port.
 * Assumes the caller presents the read index one clock before it needs the data.
 */
module tce_scratch_file #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16,
	parameter int IDX_W = 4
) (
	input  wire logic             clock,
	input  wire logic [IDX_W-1:0] rdAddr,
	output logic      [WIDTH-1:0] rdData_q,
	input  wire logic             wrEn,
	input  wire logic [IDX_W-1:0] wrAddr,
	input  wire logic [WIDTH-1:0] wrData
);

	logic [WIDTH-1:0] store [DEPTH];

	always_ff @(posedge clock) begin
		if (wrEn) begin
			store[wrAddr] <= wrData;
		end
	end

	always_ff @(posedge clock) begin
		rdData_q <= store[rdAddr];
	end

endmodule

/* File: hw/tce_exec_core.sv */
/*
 * Trainer CPU executor: fetch and execute of the 8-bit instruction set, panel load/run,
 * byte I/O, DMA-in/out and interrupt cycles, plus a small Wishbone slave for control and status.
 * Assumes a byte RAM that answers a read within three clocks of memRe rising and writes on memWe.
 */
module tce_exec_core (
	input  wire logic                         clock,
	input  wire logic                         rst,
	input  wire logic                         cyc_i,
	input  wire logic                         stb_i,
	input  wire logic                         we_i,
	input  wire logic [tce_pkg::WB_ADR_W-1:0] adr_i,
	input  wire logic [3:0]                   sel_i,
	input  wire logic [31:0]                  dat_i,
	output logic      [31:0]                  dat_o,
	output logic                              ack_o,
	input  wire logic                         panelClearKey,
	input  wire logic                         loadModeSwitch,
	input  wire logic                         panelStartKey,
	input  wire logic                         panelInputKey,
	input  wire logic [7:0]                   byteSwitches,
	input  wire logic                         extFlagOne,
	input  wire logic                         extFlagTwo,
	input  wire logic                         extFlagThree,
	input  wire logic                         intReq,
	input  wire logic                         extDmaInReq,
	input  wire logic [7:0]                   extDmaData,
	output logic      [tce_pkg::ADDR_W-1:0]   memAddr,
	output logic                              memRe,
	output logic                              memWe,
	output logic      [7:0]                   memWrData,
	input  wire logic [7:0]                   memRdData,
	output logic      [7:0]                   displayByte,
	output logic                              extFlagFour,
	output logic      [2:0]                   stateCode
);
	import tce_pkg::*;

	tce_state_t  state_q, nextState, resumeState;
	logic [2:0]  phase_q;
	logic [7:0]  ir_q, accum_q, mdr_q, tSave_q, dmaByte_q, ctrl_q, inByte_q, display_q;
	logic [3:0]  pSel_q, xSel_q, opHi, opLo, selIdx;
	logic        carryFlag_q, ie_q, running_q, ef4_q, softClear_q;
	logic        startPrev_q, inPrev_q, startPend_q, dmaInPend_q, dmaOutPend_q;
	logic [15:0] regVal_q, memAddr_q, rdData, wrData, regInc, regDec;
	logic        memRe_q, memWe_q, ack_q;
	logic [7:0]  memWrData_q;
	logic [31:0] datOut_q;
	logic        clearNow, startPress, inPress, cycEnd, atWrite, wrEn;
	logic        memAccess, memWrite, immForm, branchBase, branchTaken, aluCarry, wbTake;
	logic [7:0]  aluRes, storeByte;
	logic [8:0]  sum;

	assign opHi       = ir_q[7:4];
	assign opLo       = ir_q[3:0];
	assign clearNow   = rst | panelClearKey | softClear_q;
	assign startPress = panelStartKey & ~startPrev_q;
	assign inPress    = panelInputKey & ~inPrev_q;
	assign cycEnd     = (phase_q == PH_END);
	assign atWrite    = (phase_q == PH_WRITE);
	assign immForm    = opLo[3] & (opLo[2:0] != ALU_SHIFT_RIGHT);
	assign regInc     = regVal_q + 16'h0001;
	assign regDec     = regVal_q - 16'h0001;
	assign wbTake     = cyc_i & stb_i & ~ack_q;

	tce_scratch_file #(
		.WIDTH (ADDR_W),
		.DEPTH (REG_COUNT),
		.IDX_W (REG_IDX_W)
	) uScratch (
		.clock    (clock),
		.rdAddr   (selIdx),
		.rdData_q (rdData),
		.wrEn     (wrEn),
		.wrAddr   (selIdx),
		.wrData   (wrData)
	);

	// Short-branch condition; N bit 3 inverts the sense.
	always_comb begin
		case (opLo[2:0])
			3'h0:    branchBase = 1'b1;
			3'h2:    branchBase = (accum_q == 8'h00);
			3'h3:    branchBase = carryFlag_q;
			3'h4:    branchBase = extFlagOne;
			3'h5:    branchBase = extFlagTwo;
			3'h6:    branchBase = extFlagThree;
			3'h7:    branchBase = ef4_q;
			default: branchBase = 1'b0;
		endcase
		branchTaken = branchBase ^ opLo[3];
	end

	always_comb begin
		sum      = 9'h000;
		aluRes   = accum_q;
		aluCarry = carryFlag_q;
		case (opLo[2:0])
			3'h0: aluRes = mdr_q;
			3'h1: aluRes = accum_q | mdr_q;
			3'h2: aluRes = accum_q & mdr_q;
			3'h3: aluRes = accum_q ^ mdr_q;
			3'h4: begin
				sum      = {1'b0, accum_q} + {1'b0, mdr_q};
				aluRes   = sum[7:0];
				aluCarry = sum[8];
			end
			3'h5: begin
				sum      = {1'b0, mdr_q} + {1'b0, ~accum_q} + 9'h001;
				aluRes   = sum[7:0];
				aluCarry = sum[8];
			end
			3'h6: begin
				aluRes   = {1'b0, accum_q[7:1]};
				aluCarry = accum_q[0];
			end
			default: begin
				sum      = {1'b0, accum_q} + {1'b0, ~mdr_q} + 9'h001;
				aluRes   = sum[7:0];
				aluCarry = sum[8];
			end
		endcase
	end

	// Memory direction and the byte that a write cycle puts out.
	always_comb begin
		memAccess = (state_q == S_FETCH) || (state_q == S_EXEC) || (state_q == S_DMA_IN) ||
			(state_q == S_DMA_OUT);
		memWrite  = (state_q == S_DMA_IN) || ((state_q == S_EXEC) && ((opHi == OP_STORE_VIA_REG) ||
			((opHi == OP_BYTE_IO) && opLo[3]) || (ir_q == OP_SAVE_T)));
		if (state_q == S_DMA_IN) begin
			storeByte = dmaByte_q;
		end else if (opHi == OP_STORE_VIA_REG) begin
			storeByte = accum_q;
		end else if (opHi == OP_BYTE_IO) begin
			storeByte = ctrl_q[CTRL_SW_INHIBIT] ? inByte_q : byteSwitches;
		end else begin
			storeByte = tSave_q;
		end
	end

	// Register selection and the value written back at the write phase.
	always_comb begin
		selIdx = pSel_q;
		wrEn   = 1'b0;
		wrData = regInc;
		case (state_q)
			S_FETCH: wrEn = atWrite;
			S_START: begin
				selIdx = 4'h0;
				wrEn   = atWrite;
				wrData = PC_START;
			end
			S_DMA_IN, S_DMA_OUT: begin
				selIdx = 4'h0;
				wrEn   = atWrite;
			end
			S_EXEC: begin
				case (opHi)
					OP_SHORT_BRANCH, OP_SET_PC_SELECTOR, OP_SET_X_SELECTOR: selIdx = pSel_q;
					OP_BYTE_IO, OP_CONTROL: selIdx = xSel_q;
					OP_ALU: selIdx = immForm ? pSel_q : xSel_q;
					default: selIdx = opLo;
				endcase
				case (opHi)
					OP_INCREMENT, OP_LOAD_ADVANCE: wrEn = atWrite;
					OP_REG_DECREMENT: begin
						wrEn   = atWrite;
						wrData = regDec;
					end
					OP_SHORT_BRANCH: begin
						wrEn = atWrite;
						if (branchTaken) begin
							wrData = {regVal_q[15:8], mdr_q};
						end
					end
					OP_BYTE_IO: wrEn = atWrite & ~opLo[3];
					OP_CONTROL: wrEn = atWrite & (opLo[3:1] == 3'h0);
					OP_PUT_LOW_BYTE: begin
						wrEn   = atWrite;
						wrData = {regVal_q[15:8], accum_q};
					end
					OP_PUT_HIGH_BYTE: begin
						wrEn   = atWrite;
						wrData = {accum_q, regVal_q[7:0]};
					end
					OP_ALU: wrEn = atWrite & immForm;
					default: wrEn = 1'b0;
				endcase
			end
			default: wrEn = 1'b0;
		endcase
		if (clearNow) begin
			selIdx = 4'h0;
			wrEn   = 1'b1;
			wrData = R0_CLEAR;
		end
	end

	always_comb begin
		if (extDmaInReq) begin
			resumeState = S_DMA_IN;
		end else if (intReq && ie_q) begin
			resumeState = S_INT;
		end else if (ir_q == OP_WAIT) begin
			resumeState = S_WAIT;
		end else begin
			resumeState = S_FETCH;
		end
		case (state_q)
			S_HALT: begin
				if (dmaInPend_q || extDmaInReq) begin
					nextState = S_DMA_IN;
				end else if (dmaOutPend_q) begin
					nextState = S_DMA_OUT;
				end else if (startPend_q) begin
					nextState = S_START;
				end else begin
					nextState = S_HALT;
				end
			end
			S_START: nextState = S_FETCH;
			S_FETCH: nextState = S_EXEC;
			S_INT:   nextState = extDmaInReq ? S_DMA_IN : S_FETCH;
			S_DMA_IN, S_DMA_OUT: nextState = running_q ? resumeState : S_HALT;
			default: nextState = resumeState;
		endcase
	end

	always_ff @(posedge clock) begin
		if (clearNow) begin
			phase_q <= 3'h0;
		end else begin
			phase_q <= phase_q + 3'h1;
		end
	end

	always_ff @(posedge clock) begin
		if (clearNow) begin
			state_q   <= S_HALT;
			running_q <= 1'b0;
		end else if (cycEnd) begin
			state_q <= nextState;
			if (state_q == S_START) begin
				running_q <= 1'b1;
			end
		end
	end

	// Panel keys become pending requests, served at the next machine-cycle boundary.
	always_ff @(posedge clock) begin
		startPrev_q <= panelStartKey;
		inPrev_q    <= panelInputKey;
		if (clearNow) begin
			startPend_q  <= 1'b0;
			dmaInPend_q  <= 1'b0;
			dmaOutPend_q <= 1'b0;
		end else begin
			if (startPress && !loadModeSwitch && !running_q) begin
				startPend_q <= 1'b1;
			end else if (cycEnd && state_q == S_HALT && nextState == S_START) begin
				startPend_q <= 1'b0;
			end
			if (inPress && loadModeSwitch && !running_q) begin
				dmaInPend_q <= 1'b1;
			end else if (cycEnd && state_q == S_HALT && nextState == S_DMA_IN && dmaInPend_q) begin
				dmaInPend_q <= 1'b0;
			end
			if (startPress && loadModeSwitch && !running_q) begin
				dmaOutPend_q <= 1'b1;
			end else if (cycEnd && state_q == S_HALT && nextState == S_DMA_OUT) begin
				dmaOutPend_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (cycEnd && nextState == S_DMA_IN) begin
			dmaByte_q <= (state_q == S_HALT && dmaInPend_q) ? byteSwitches : extDmaData;
		end
	end

	always_ff @(posedge clock) begin
		if (clearNow) begin
			ir_q <= OP_WAIT;
		end else if (state_q == S_FETCH && phase_q == PH_SAMPLE) begin
			ir_q <= memRdData;
		end
	end

	always_ff @(posedge clock) begin
		if (phase_q == PH_LATCH) begin
			regVal_q <= rdData;
		end
		if (phase_q == PH_SAMPLE) begin
			mdr_q <= memRdData;
		end
	end

	// RAM port; the 16-bit address is the selected register itself.
	always_ff @(posedge clock) begin
		if (clearNow) begin
			memAddr_q   <= R0_CLEAR;
			memRe_q     <= 1'b0;
			memWe_q     <= 1'b0;
			memWrData_q <= 8'h00;
		end else begin
			if (phase_q == PH_LATCH && memAccess) begin
				memAddr_q   <= rdData;
				memWrData_q <= storeByte;
			end
			if (phase_q == PH_LATCH) begin
				memRe_q <= memAccess & ~memWrite;
			end else if (phase_q == PH_SAMPLE) begin
				memRe_q <= 1'b0;
			end
			memWe_q <= (phase_q == PH_MEMWR) & memAccess & memWrite;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			accum_q     <= 8'h00;
			carryFlag_q <= 1'b0;
		end else if (atWrite && state_q == S_EXEC) begin
			case (opHi)
				OP_LOAD_VIA_N, OP_LOAD_ADVANCE: accum_q <= mdr_q;
				OP_GET_LOW_BYTE:  accum_q <= regVal_q[7:0];
				OP_GET_HIGH_BYTE: accum_q <= regVal_q[15:8];
				OP_ALU: begin
					accum_q <= aluRes;
					if (opLo[2]) begin
						carryFlag_q <= aluCarry;
					end
				end
				default: accum_q <= accum_q;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (clearNow) begin
			pSel_q  <= 4'h0;
			xSel_q  <= 4'h0;
			ie_q    <= 1'b1;
			tSave_q <= 8'h00;
		end else if (atWrite && state_q == S_INT) begin
			tSave_q <= {xSel_q, pSel_q};
			xSel_q  <= INT_X_SEL;
			pSel_q  <= INT_P_SEL;
			ie_q    <= 1'b0;
		end else if (atWrite && state_q == S_EXEC) begin
			if (opHi == OP_SET_PC_SELECTOR) begin
				pSel_q <= opLo;
			end else if (opHi == OP_SET_X_SELECTOR) begin
				xSel_q <= opLo;
			end else if (opHi == OP_CONTROL && opLo[3:1] == 3'h0) begin
				{xSel_q, pSel_q} <= mdr_q;
				ie_q             <= ~opLo[0];
			end
		end
	end

	// A key press landing in the same clock as an I/O opcode's write phase keeps the flag set.
	always_ff @(posedge clock) begin
		if (clearNow) begin
			ef4_q <= 1'b0;
		end else if (inPress && !loadModeSwitch) begin
			ef4_q <= 1'b1;
		end else if (atWrite && state_q == S_EXEC && opHi == OP_BYTE_IO) begin
			ef4_q <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			display_q <= 8'h00;
		end else if (atWrite) begin
			if (state_q == S_DMA_IN) begin
				display_q <= dmaByte_q;
			end else if (state_q == S_DMA_OUT) begin
				display_q <= mdr_q;
			end else if (state_q == S_EXEC && opHi == OP_BYTE_IO && !opLo[3]) begin
				display_q <= mdr_q;
			end
		end
	end

	// Wishbone slave: one wait state, unmapped reads return zero and unmapped writes are dropped.
	always_ff @(posedge clock) begin
		if (rst) begin
			ack_q       <= 1'b0;
			datOut_q    <= 32'h0000_0000;
			ctrl_q      <= CTRL_RESET;
			inByte_q    <= INBYTE_RESET;
			softClear_q <= 1'b0;
		end else begin
			ack_q       <= wbTake;
			softClear_q <= 1'b0;
			datOut_q    <= 32'h0000_0000;
			if (wbTake && we_i && sel_i[0]) begin
				if (adr_i == REG_CTRL) begin
					ctrl_q      <= dat_i[7:0] & 8'h02;
					softClear_q <= dat_i[CTRL_SOFT_CLEAR];
				end else if (adr_i == REG_INBYTE) begin
					inByte_q <= dat_i[7:0];
				end
			end else if (wbTake && !we_i) begin
				if (adr_i == REG_CTRL) begin
					datOut_q <= {24'h000000, ctrl_q};
				end else if (adr_i == REG_STATUS) begin
					datOut_q <= {9'h000, running_q, ef4_q, state_q, ie_q, carryFlag_q, xSel_q, pSel_q,
						accum_q};
				end else if (adr_i == REG_INBYTE) begin
					datOut_q <= {24'h000000, inByte_q};
				end else if (adr_i == REG_DISPLAY) begin
					datOut_q <= {24'h000000, display_q};
				end
			end
		end
	end

	assign dat_o       = datOut_q;
	assign ack_o       = ack_q;
	assign memAddr     = memAddr_q;
	assign memRe       = memRe_q;
	assign memWe       = memWe_q;
	assign memWrData   = memWrData_q;
	assign displayByte = display_q;
	assign extFlagFour = ef4_q;
	assign stateCode   = state_q;

endmodule

/* File: tb/tce_exec_core_checker.sv */
/*
 * Port assertions for the trainer CPU executor: bus handshake, RAM cycle shape and panel flags.
 * Assumes it is bound to the executor and sees only its ports.
 */
module tce_exec_core_checker
	import tce_pkg::*;
(
	input wire logic                  clock,
	input wire logic                  rst,
	input wire logic                  cyc_i,
	input wire logic                  stb_i,
	input wire logic                  ack_o,
	input wire logic [31:0]           dat_o,
	input wire logic                  memRe,
	input wire logic                  memWe,
	input wire logic [ADDR_W-1:0]     memAddr,
	input wire logic                  panelInputKey,
	input wire logic                  loadModeSwitch,
	input wire logic                  panelClearKey,
	input wire logic                  extFlagFour,
	input wire logic [2:0]            stateCode
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	property p_ackTake; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
	a_ackTake: assert property (p_ackTake) else $error("request not answered next cycle");
	property p_ackOne; ack_o |=> !ack_o; endproperty
	a_ackOne: assert property (p_ackOne) else $error("ack held longer than one cycle");
	property p_datIdle; !ack_o |-> dat_o == 32'h0; endproperty
	a_datIdle: assert property (p_datIdle) else $error("read data outside ack cycle");
	// A clear may cut a read short; the core then sits halted, which is accepted in place of the strobe.
	property p_reLen; $rose(memRe) |-> (memRe || stateCode == S_HALT) [*3] ##1 !memRe; endproperty
	a_reLen: assert property (p_reLen) else $error("read strobe not three clocks");
	property p_cycle; $rose(memRe) |=> (!$rose(memRe) && !memWe) [*7]; endproperty
	a_cycle: assert property (p_cycle) else $error("second access inside one machine cycle");
	property p_addr; memRe && $past(memRe) |-> $stable(memAddr); endproperty
	a_addr: assert property (p_addr) else $error("address moved during read");
	property p_wePulse; memWe |=> !memWe; endproperty
	a_wePulse: assert property (p_wePulse) else $error("write strobe wider than one clock");
	property p_flagFour; $rose(panelInputKey) && !loadModeSwitch |-> ##[1:3] extFlagFour; endproperty
	a_flagFour: assert property (p_flagFour) else $error("input key did not raise flag four");
	property p_clear; panelClearKey |=> stateCode == S_HALT; endproperty
	a_clear: assert property (p_clear) else $error("clear did not halt");
endmodule

bind tce_exec_core tce_exec_core_checker tce_exec_core_checker_i (.clock, .rst, .cyc_i, .stb_i, .ack_o, .dat_o,
	.memRe, .memWe, .memAddr, .panelInputKey, .loadModeSwitch, .panelClearKey, .extFlagFour, .stateCode);

/* File: tb/tce_ram_model.sv */
/*
 * Byte RAM on the executor's memory port, with a selectable read latency.
 * Assumes the strobe timing of the executor; LAT may be 0 or 1 only.
 */
module tce_ram_model #(
	parameter int LAT = 1
) (
	input  wire logic        clock,
	input  wire logic [15:0] memAddr,
	input  wire logic        memRe,
	input  wire logic        memWe,
	input  wire logic [7:0]  memWrData,
	output logic      [7:0]  memRdData
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] mem [0:65535];
	int         waitCnt = 0;

	initial memRdData = 8'h00;
	// Outside a read, and in a read until LAT is met, the bus toggles, so a sample one clock early sees the old byte inverted.
	always @(posedge clock) begin
		if (memWe)
			mem[memAddr] <= memWrData;
		waitCnt <= memRe ? waitCnt + 1 : 0;
		memRdData <= (memRe && waitCnt >= LAT) ? mem[memAddr] : ~memRdData;
	end
endmodule

/* File: tb/trainer_cpu_instruction_exec_bench.sv */
/*
 * Self-checking bench: bus register checks, a program run from the panel, clear, and load mode.
 * Assumes the executor and a slow-answering RAM model; panel keys are driven here.
 */
module trainer_cpu_instruction_exec_bench;
	timeunit 1ns;
	timeprecision 100ps;
	import tce_pkg::*;

	logic        clock = 1'h0, rst = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0, ack;
	logic        clr = 1'h0, ldm = 1'h0, stKey = 1'h0, inKey = 1'h0, ef1 = 1'h0, re, wr, ef4;
	logic        ef2 = 1'h0, dmaReq = 1'h0;
	logic [7:0]  adr = 8'h00, sw = 8'h00, dmaDat = 8'h00, memRd, memWd, disp;
	logic [3:0]  sel = 4'h0;
	logic [31:0] wdat = 32'h0, rdat, r;
	logic [15:0] addr;
	logic [2:0]  state;
	int          nMismatch = 0, nTests = 0, cycles = 0;
	logic [7:0]  res [5] = '{8'h13, 8'h7F, 8'h86, 8'h86, 8'hC3};
	logic [7:0]  prog [50] = '{8'hF8, 8'h00, 8'hB3, 8'hF8, 8'h80, 8'hA3, 8'hF8, 8'h12, 8'hB1, 8'hF8,
		8'hFF, 8'hA1, 8'h11, 8'h91, 8'h53, 8'h81, 8'h21, 8'h81, 8'hE3, 8'hF6, 8'h13, 8'h53, 8'hF8,
		8'h05, 8'hF7, 8'h13, 8'h53, 8'h43, 8'h53, 8'hF8, 8'h03, 8'hF5, 8'hF8, 8'h00, 8'h60, 8'h68,
		8'h60, 8'h35, 8'h2A, 8'h34, 8'h2C, 8'h30, 8'h2A, 8'hF8, 8'h40, 8'hA4, 8'hF8, 8'h00, 8'hB4, 8'hD4};

	tce_exec_core tce_exec_core_i (.clock(clock), .rst(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
		.adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .panelClearKey(clr),
		.loadModeSwitch(ldm), .panelStartKey(stKey), .panelInputKey(inKey), .byteSwitches(sw),
		.extFlagOne(ef1), .extFlagTwo(ef2), .extFlagThree(1'h0), .intReq(1'h0), .extDmaInReq(dmaReq),
		.extDmaData(dmaDat), .memAddr(addr), .memRe(re), .memWe(wr), .memWrData(memWd),
		.memRdData(memRd), .displayByte(disp), .extFlagFour(ef4), .stateCode(state));
	tce_ram_model #(.LAT(1)) tce_ram_model_i (.clock(clock), .memAddr(addr), .memRe(re), .memWe(wr),
		.memWrData(memWd), .memRdData(memRd));

	always #10 clock = ~clock;

	task automatic finishTest();
		$display("Checks %0d, mismatches %0d", nTests, nMismatch);
		if (nMismatch == 0 && nTests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		nTests++;
		if (got !== exp) begin
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
			nMismatch++;
		end
	endtask

	function automatic logic [7:0] m(input int a);
		return tce_ram_model_i.mem[a];
	endfunction

	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge clock);
		{cyc, stb, we, adr, wdat, sel} <= {2'h3, w, a, d, s};
		do @(posedge clock); while (ack !== 1'h1);
		r = rdat;
		{cyc, stb, we} <= 3'h0;
	endtask

	// The executor serves a press within two machine cycles, so 24 clocks always cover it.
	task automatic key(input logic s, input logic i);
		@(posedge clock);
		{stKey, inKey} <= {s, i};
		@(posedge clock);
		{stKey, inKey} <= 2'h0;
		repeat (24) @(posedge clock);
	endtask

	task automatic clearPulse();
		@(posedge clock);
		clr <= 1'h1;
		@(posedge clock);
		clr <= 1'h0;
		repeat (2) @(posedge clock);
	endtask

	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			nMismatch++;
			finishTest();
		end
	end

	initial begin
		repeat (3) @(posedge clock);
		rst <= 1'h0;
		wb(1'h0, REG_STATUS, 32'h0, 4'hF);
		chk(r, 32'h00020000);
		chk({23'h0, ef4, disp}, 32'h0);
		wb(1'h1, REG_INBYTE, 32'h5A, 4'h1);
		wb(1'h1, REG_INBYTE, 32'hA5, 4'h0);
		wb(1'h0, REG_INBYTE, 32'h0, 4'hF);
		chk(r, 32'h5A);
		wb(1'h0, 8'h10, 32'h0, 4'hF);
		chk(r, 32'h0);
		foreach (prog[i]) tce_ram_model_i.mem[i + 1] = prog[i];
		tce_ram_model_i.mem[16'h40] = 8'h30;
		tce_ram_model_i.mem[16'h41] = 8'h40;
		sw <= 8'hC3;
		ef1 <= 1'h1;
		clearPulse();
		key(1'h0, 1'h1);
		chk({31'h0, ef4}, 32'h1);
		@(posedge clock);
		stKey <= 1'h1;
		@(posedge clock);
		stKey <= 1'h0;
		while (re !== 1'h1) @(posedge clock);
		chk({16'h0, addr}, 32'h1);
		while (addr !== 16'h0041) @(posedge clock);
		repeat (16) @(posedge clock);
		for (int i = 0; i < 5; i++) chk({24'h0, m(8'h80 + i)}, {24'h0, res[i]});
		chk({23'h0, ef4, disp}, 32'hC3);
		wb(1'h0, REG_STATUS, 32'h0, 4'hF);
		chk(r & 32'h0041FFFF, 32'h00413400);
		wb(1'h1, REG_CTRL, 32'h1, 4'h1);
		repeat (2) @(posedge clock);
		wb(1'h0, REG_STATUS, 32'h0, 4'hF);
		chk(r & 32'h005C0F00, 32'h0);
		ldm <= 1'h1;
		sw <= 8'hA5;
		key(1'h0, 1'h1);
		chk({16'h0, m(0), disp}, 32'h0000A5A5);
		sw <= 8'h3C;
		key(1'h0, 1'h1);
		chk({16'h0, m(1), disp}, 32'h00003C3C);
		clearPulse();
		key(1'h1, 1'h0);
		chk({24'h0, disp}, 32'hA5);
		key(1'h1, 1'h0);
		chk({24'h0, disp}, 32'h3C);
		sw <= 8'h77;
		key(1'h0, 1'h1);
		chk({24'h0, m(2)}, 32'h77);
		// An outside source fills the next address through the same channel while halted.
		dmaDat <= 8'h5E;
		dmaReq <= 1'h1;
		while (state !== S_DMA_IN) @(posedge clock);
		dmaReq <= 1'h0;
		repeat (8) @(posedge clock);
		chk({16'h0, m(3), disp}, 32'h00005E5E);
		finishTest();
	end
endmodule
